// [core/seg_offset_pkg.sv]
// Overview of operation
// - Offset space starts at zero origin
// - Continuous offsets use blocks with initial offset
// - Subblocks only when receiver allows random offsets
// - Parameter field holds first byte displacement
// - No offsets: concatenate payloads by sequence count
// - Sequence count wraps FFFF to zero
// - Login declares per-category support and mode
// - Sender segments per declared receiver requirements
// - Several blocks per sequence, own offset space
// - Unsupported category: bit clear, contiguous block
// - Continuous mode: bit set, first frame initial
// - Next offset adds previous payload length
// - Random mode: offset-present bit set
// - Subblock first frame initial, then accumulate
// - Unsupported but bit set: reject unsupported
// - Continuous only, random seen: reject bounds
`default_nettype none
package seg_offset_pkg;
    // ----------------------------------------
    // Sizes and register map
    // ----------------------------------------
    localparam int NCAT = 4;
    localparam int CAT_W = 2;
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] TXCNT_OFS = 8'h08;
    localparam logic [7:0] REJCNT_OFS = 8'h0c;
    localparam int CFG_SUP_LSB = 0;
    localparam int CFG_RAND_BIT = 8;
    localparam int STAT_SEQ_LSB = 0;
    localparam int STAT_ACT_BIT = 16;
    localparam int STAT_RAND_BIT = 17;
    localparam logic [NCAT-1:0] CFG_SUP_RST = 4'h0;
    localparam logic CFG_RAND_RST = 1'b0;
    localparam logic [31:0] OFS_ORIGIN = 32'h0000_0000;
    localparam logic [15:0] SEQ_WRAP_LAST = 16'hffff;
    localparam logic [15:0] SEQ_STEP = 16'h0001;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        RJ_NONE = 2'b00,
        RJ_RO_UNSUP = 2'b01,
        RJ_RO_BOUNDS = 2'b10,
        RJ_SEQ_GAP = 2'b11
    } rej_reason_e;

    typedef enum logic {
        SQ_IDLE = 1'b0,
        SQ_ACTIVE = 1'b1
    } seq_state_e;

    typedef struct packed {
        logic [NCAT-1:0] sup;
        logic rnd;
        logic [NCAT-1:0][31:0] acc;
        logic tx_valid;
        logic tx_ro_present;
        logic [CAT_W-1:0] tx_cat;
        logic [31:0] tx_param;
        logic [15:0] tx_len;
        logic seg_err;
        seq_state_e sq;
        logic [15:0] exp_seq;
        logic [NCAT-1:0][31:0] exp_ro;
        logic [NCAT-1:0] exp_ok;
        logic [NCAT-1:0][31:0] cat_pos;
        logic rx_accept;
        logic rx_rej;
        rej_reason_e rx_reason;
        logic rx_use_ro;
        logic [CAT_W-1:0] rx_out_cat;
        logic [31:0] rx_place;
        logic [15:0] rx_out_len;
        logic [15:0] tx_cnt;
        logic [15:0] rej_cnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } st_s;
endpackage
`default_nettype wire

// [core/seg_offset.sv]
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module seg_offset
    import seg_offset_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Upper level: block or subblock start
    input wire logic seg_start,
    input wire logic seg_sub,
    input wire logic [CAT_W-1:0] seg_cat,
    input wire logic [31:0] seg_iro,
    // Upper level: one payload to frame
    input wire logic frm_req,
    input wire logic [CAT_W-1:0] frm_cat,
    input wire logic [15:0] frm_len,
    // Outgoing frame header fields
    output logic tx_valid,
    output logic tx_ro_present,
    output logic [CAT_W-1:0] tx_cat,
    output logic [31:0] tx_param,
    output logic [15:0] tx_len,
    output logic seg_err,
    // Incoming frame header fields
    input wire logic rx_frame,
    input wire logic rx_first,
    input wire logic rx_last,
    input wire logic [CAT_W-1:0] rx_cat,
    input wire logic rx_ro_present,
    input wire logic [31:0] rx_param,
    input wire logic [15:0] rx_seq,
    input wire logic [15:0] rx_len,
    // Reassembly result
    output logic rx_accept,
    output logic rx_rej,
    output logic [1:0] rx_reason,
    output logic rx_use_ro,
    output logic [CAT_W-1:0] rx_out_cat,
    output logic [31:0] rx_place,
    output logic [15:0] rx_out_len
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    function automatic logic reg_mapped(input logic [7:0] addr);
        reg_mapped = reg_hit(addr, CFG_OFS) || reg_hit(addr, STAT_OFS) ||
                     reg_hit(addr, TXCNT_OFS) || reg_hit(addr, REJCNT_OFS);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    st_s s;
    st_s n;
    logic rx_start;
    logic [31:0] rx_exp_ro;
    logic rx_exp_ok;
    logic [31:0] pos_now;

    always_comb begin
        n = s;
        rx_start = 1'b0;
        rx_exp_ro = OFS_ORIGIN;
        rx_exp_ok = 1'b0;
        pos_now = OFS_ORIGIN;
        if (ce) begin
            n.tx_valid = 1'b0;
            n.seg_err = 1'b0;
            n.rx_accept = 1'b0;
            n.rx_rej = 1'b0;
            n.pready = 1'b0;
            n.pslverr = 1'b0;

            // ----------------------------------------
            // Register access, one wait state
            // ----------------------------------------
            if (psel && penable && !s.pready) begin
                n.pready = 1'b1;
                n.pslverr = !reg_mapped(paddr);
                n.prdata = 32'h0000_0000;
                if (pwrite) begin
                    if (reg_hit(paddr, CFG_OFS)) begin
                        // Login outcome from the remote recipient
                        n.sup = pwdata[CFG_SUP_LSB +: NCAT];
                        n.rnd = pwdata[CFG_RAND_BIT];
                    end
                end else begin
                    if (reg_hit(paddr, CFG_OFS)) begin
                        n.prdata[CFG_SUP_LSB +: NCAT] = s.sup;
                        n.prdata[CFG_RAND_BIT] = s.rnd;
                    end else if (reg_hit(paddr, STAT_OFS)) begin
                        n.prdata[STAT_SEQ_LSB +: 16] = s.exp_seq;
                        n.prdata[STAT_ACT_BIT] = (s.sq == SQ_ACTIVE);
                        n.prdata[STAT_RAND_BIT] = s.rnd;
                    end else if (reg_hit(paddr, TXCNT_OFS)) begin
                        n.prdata[15:0] = s.tx_cnt;
                    end else if (reg_hit(paddr, REJCNT_OFS)) begin
                        n.prdata[15:0] = s.rej_cnt;
                    end
                end
            end

            // ----------------------------------------
            // Segmentation
            // ----------------------------------------
            if (seg_start) begin
                if (seg_sub && !(s.sup[seg_cat] && s.rnd)) begin
                    // Subblock refused, accumulator untouched
                    n.seg_err = 1'b1;
                end else begin
                    n.acc[seg_cat] = seg_iro;
                end
            end
            if (frm_req) begin
                n.tx_valid = 1'b1;
                n.tx_cat = frm_cat;
                n.tx_len = frm_len;
                // Bit follows what the recipient declared
                n.tx_ro_present = s.sup[frm_cat];
                n.tx_param = s.sup[frm_cat] ? n.acc[frm_cat] : OFS_ORIGIN;
                // Unsupported categories still advance, keeping the block contiguous
                n.acc[frm_cat] = n.acc[frm_cat] + {16'h0000, frm_len};
                n.tx_cnt = s.tx_cnt + SEQ_STEP;
            end

            // ----------------------------------------
            // Reassembly checks
            // ----------------------------------------
            if (rx_frame) begin
                // Idle link starts a sequence even when the first frame was lost
                case (s.sq)
                    SQ_IDLE: rx_start = 1'b1;
                    SQ_ACTIVE: rx_start = rx_first;
                    default: rx_start = 1'b1;
                endcase
                if (rx_start) begin
                    n.exp_ok = '0;
                    n.exp_seq = rx_seq;
                    n.sq = SQ_ACTIVE;
                    for (int c = 0; c < NCAT; c++) begin
                        n.cat_pos[c] = OFS_ORIGIN;
                    end
                end
                rx_exp_ro = n.exp_ro[rx_cat];
                rx_exp_ok = n.exp_ok[rx_cat];
                pos_now = n.cat_pos[rx_cat];
                n.rx_out_cat = rx_cat;
                n.rx_out_len = rx_len;
                n.rx_use_ro = rx_ro_present;
                if (!s.sup[rx_cat] && rx_ro_present) begin
                    n.rx_rej = 1'b1;
                    n.rx_reason = RJ_RO_UNSUP;
                end else if (rx_ro_present && !s.rnd && rx_exp_ok && rx_param != rx_exp_ro) begin
                    // A jump within a continuous category counts as random
                    n.rx_rej = 1'b1;
                    n.rx_reason = RJ_RO_BOUNDS;
                end else if (!rx_ro_present && rx_seq != n.exp_seq) begin
                    n.rx_rej = 1'b1;
                    n.rx_reason = RJ_SEQ_GAP;
                end else begin
                    n.rx_accept = 1'b1;
                    n.rx_reason = RJ_NONE;
                    n.rx_place = rx_ro_present ? rx_param : pos_now;
                    n.cat_pos[rx_cat] = pos_now + {16'h0000, rx_len};
                    n.exp_ro[rx_cat] = rx_param + {16'h0000, rx_len};
                    n.exp_ok[rx_cat] = rx_ro_present;
                    // Sixteen-bit add wraps to zero after the top count
                    n.exp_seq = rx_seq + SEQ_STEP;
                end
                if (n.rx_rej) begin
                    n.rej_cnt = s.rej_cnt + SEQ_STEP;
                end
                if (rx_last) begin
                    n.sq = SQ_IDLE;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s <= '0;
            s.sup <= CFG_SUP_RST;
            s.rnd <= CFG_RAND_RST;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign tx_valid = s.tx_valid;
    assign tx_ro_present = s.tx_ro_present;
    assign tx_cat = s.tx_cat;
    assign tx_param = s.tx_param;
    assign tx_len = s.tx_len;
    assign seg_err = s.seg_err;
    assign rx_accept = s.rx_accept;
    assign rx_rej = s.rx_rej;
    assign rx_reason = s.rx_reason;
    assign rx_use_ro = s.rx_use_ro;
    assign rx_out_cat = s.rx_out_cat;
    assign rx_place = s.rx_place;
    assign rx_out_len = s.rx_out_len;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    a_unsup_bit_clear: assert property (
        ce && frm_req && !s.sup[frm_cat] |=> tx_valid && !tx_ro_present && tx_param == OFS_ORIGIN)
        else $error("offset bit set for unsupported category");

    a_cont_bit_set: assert property (
        ce && frm_req && s.sup[frm_cat] && !s.rnd |=> tx_valid && tx_ro_present)
        else $error("offset bit clear in continuous mode");

    a_rand_bit_set: assert property (
        ce && frm_req && s.sup[frm_cat] && s.rnd |=> tx_ro_present)
        else $error("offset bit clear in random mode");

    a_first_frame_iro: assert property (
        ce && seg_start && frm_req && frm_cat == seg_cat && s.sup[seg_cat] &&
        !(seg_sub && !s.rnd) |=> tx_param == $past(seg_iro))
        else $error("first frame lacks initial offset");

    sequence two_frames_same_cat;
        ce && frm_req && !seg_start ##1 ce && frm_req && !seg_start && frm_cat == tx_cat && tx_ro_present;
    endsequence

    a_offset_chain: assert property (
        two_frames_same_cat |=> tx_param == $past(tx_param) + {16'h0000, $past(tx_len)})
        else $error("offset not advanced by payload length");

    a_sub_refused: assert property (
        ce && seg_start && seg_sub && !(s.sup[seg_cat] && s.rnd) |=> seg_err)
        else $error("subblock accepted without random support");

    a_rej_unsup: assert property (
        ce && rx_frame && rx_ro_present && !s.sup[rx_cat] |=> rx_rej && !rx_accept && rx_reason == RJ_RO_UNSUP)
        else $error("unsupported offset frame not rejected");

    a_rej_bounds: assert property (
        ce && rx_frame && !rx_first && s.sq == SQ_ACTIVE && rx_ro_present && s.sup[rx_cat] && !s.rnd &&
        s.exp_ok[rx_cat] && rx_param != s.exp_ro[rx_cat] |=> rx_rej && rx_reason == RJ_RO_BOUNDS)
        else $error("random offset not rejected");

    a_seq_wrap: assert property (
        ce && rx_frame && !rx_first && s.sq == SQ_ACTIVE && !rx_ro_present &&
        s.exp_seq == SEQ_WRAP_LAST && rx_seq == SEQ_WRAP_LAST |=> rx_accept && s.exp_seq == 16'h0000)
        else $error("sequence count did not wrap");

    a_seq_gap: assert property (
        ce && rx_frame && !rx_first && s.sq == SQ_ACTIVE && !rx_ro_present && rx_seq != s.exp_seq
        |=> rx_rej && rx_reason == RJ_SEQ_GAP)
        else $error("out of order count accepted");

    a_origin_zero: assert property (
        ce && rx_frame && rx_first && !rx_ro_present |=> rx_accept && rx_place == OFS_ORIGIN)
        else $error("first frame not placed at origin");

    a_apb_answer: assert property (
        ce && psel && penable && !pready |=> pready)
        else $error("register access not answered");

    // ----------------------------------------
    // Bus, counter and reassembly detail checks
    // ----------------------------------------
    a_apb_pulse: assert property (
        ce && pready |=> !pready)
        else $error("register answer held too long");

    a_apb_unmapped: assert property (
        ce && psel && penable && !pready && !reg_mapped(paddr) |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");

    // A frozen cycle must not let a pulse end or a header move
    a_ce_freeze: assert property (
        !ce |=> $stable(tx_valid) && $stable(tx_param) && $stable(rx_accept) &&
        $stable(rx_place) && $stable(pready))
        else $error("state moved while enable low");

    a_tx_fields: assert property (
        ce && frm_req |=> tx_valid && tx_cat == $past(frm_cat) && tx_len == $past(frm_len))
        else $error("header fields not taken from request");

    a_tx_count: assert property (
        ce && frm_req |=> s.tx_cnt == $past(s.tx_cnt) + SEQ_STEP)
        else $error("sent frame not counted");

    a_sub_kept: assert property (
        ce && seg_start && seg_sub && !(s.sup[seg_cat] && s.rnd) && !frm_req |=>
        s.acc[$past(seg_cat)] == $past(s.acc[seg_cat]))
        else $error("refused subblock moved accumulator");

    a_one_verdict: assert property (
        ce && rx_frame |=> rx_accept != rx_rej)
        else $error("frame without single verdict");

    a_rx_fields: assert property (
        ce && rx_frame |=> rx_use_ro == $past(rx_ro_present) && rx_out_cat == $past(rx_cat) &&
        rx_out_len == $past(rx_len))
        else $error("reassembly fields not taken from header");

    a_ro_place: assert property (
        ce && rx_frame && rx_ro_present && s.sup[rx_cat] && (s.rnd || rx_first || s.sq == SQ_IDLE)
        |=> rx_accept && rx_place == $past(rx_param))
        else $error("offset frame not placed at its offset");

    a_count_place: assert property (
        ce && rx_frame && !rx_first && s.sq == SQ_ACTIVE && !rx_ro_present && rx_seq == s.exp_seq
        |=> rx_accept && rx_place == $past(s.cat_pos[rx_cat]))
        else $error("count frame not placed after previous");

    a_rej_count: assert property (
        ce && rx_frame && rx_ro_present && !s.sup[rx_cat] |=> s.rej_cnt == $past(s.rej_cnt) + SEQ_STEP)
        else $error("rejected frame not counted");

    a_seq_end: assert property (
        ce && rx_frame && rx_last |=> s.sq == SQ_IDLE)
        else $error("sequence still active after last frame");

    c_wrap_taken: cover property (ce && rx_frame && rx_seq == SEQ_WRAP_LAST ##1 rx_accept);
    c_subblock_ok: cover property (ce && seg_start && seg_sub && s.rnd && s.sup[seg_cat]);
    c_rej_unsup: cover property (rx_rej && rx_reason == RJ_RO_UNSUP);
    c_chain: cover property (two_frames_same_cat);

endmodule // seg_offset
`default_nettype wire

// [test/far_port.sv]
`timescale 1ns/10ps
`default_nettype none
module far_port (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Declared support and observed headers
    input wire logic [3:0] sup,
    input wire logic tx_valid,
    input wire logic tx_ro_present,
    input wire logic [1:0] tx_cat,
    // Tallies
    output logic [15:0] frames,
    output logic [15:0] bad
);
    // ----------------------------------------
    // Header check against login declaration
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            frames <= 16'h0000;
            bad <= 16'h0000;
        end else if (tx_valid) begin
            frames <= frames + 16'h0001;
            if (tx_ro_present !== sup[tx_cat]) begin
                bad <= bad + 16'h0001;
            end
        end
    end
endmodule // far_port
`default_nettype wire

// [test/payload_segmentation_offset_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module payload_segmentation_offset_tb;
    import seg_offset_pkg::*;
    logic ref_clk = 1'b0, rstn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic seg_start = 1'b0, seg_sub = 1'b0, frm_req = 1'b0, rx_frame = 1'b0, rx_first = 1'b0;
    logic rx_last = 1'b0, rx_ro_present = 1'b0, lst = 1'b0, e, pready, pslverr, tx_valid, tx_ro_present;
    logic seg_err, rx_accept, rx_rej, rx_use_ro;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, seg_iro = 32'h0, rx_param = 32'h0, prdata, tx_param, rx_place;
    logic [31:0] seed = 32'h0000_1468, r, iro, acc;
    logic [1:0] seg_cat = 2'h0, frm_cat = 2'h0, rx_cat = 2'h0, tx_cat, rx_out_cat, rx_reason;
    logic [15:0] frm_len = 16'h0, rx_seq = 16'h0, rx_len = 16'h0, tx_len, rx_out_len, frames, bad, len;
    logic [3:0] sup = 4'hb;
    int n_mismatch = 0, total_checks = 0, nf = 0;
    always #4 ref_clk = ~ref_clk;
    seg_offset DUT (.ref_clk, .rstn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .seg_start, .seg_sub, .seg_cat, .seg_iro, .frm_req, .frm_cat, .frm_len, .tx_valid,
        .tx_ro_present, .tx_cat, .tx_param, .tx_len, .seg_err, .rx_frame, .rx_first, .rx_last, .rx_cat,
        .rx_ro_present, .rx_param, .rx_seq, .rx_len, .rx_accept, .rx_rej, .rx_reason, .rx_use_ro,
        .rx_out_cat, .rx_place, .rx_out_len);
    far_port PEER (.ref_clk, .rstn, .sup, .tx_valid, .tx_ro_present, .tx_cat, .frames, .bad);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Unsupported categories carry no offset
    function automatic logic [31:0] ro_exp(input logic s, input logic [31:0] a);
        return s ? a : 32'h0;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) chk(32'h1, 32'h0);
    endtask
    task automatic seg(input logic st, input logic sb, input logic [1:0] c, input logic rq);
        @(posedge ref_clk);
        seg_start <= st; seg_sub <= sb; seg_cat <= c; frm_cat <= c; seg_iro <= iro; frm_req <= rq;
        frm_len <= len;
        @(posedge ref_clk);
        seg_start <= 1'b0; frm_req <= 1'b0;
        #1;
        if (rq) nf++;
        if (rq) chk({14'h0, tx_cat, tx_len}, {14'h0, c, len});
    endtask
    // Two frames back to back, request held across both
    task automatic pair(input logic [1:0] c, input logic [15:0] l1, input logic [15:0] l2);
        @(posedge ref_clk);
        frm_req <= 1'b1; frm_cat <= c; frm_len <= l1;
        @(posedge ref_clk);
        frm_len <= l2;
        #1;
        chk(tx_param, ro_exp(sup[c], acc));
        @(posedge ref_clk);
        frm_req <= 1'b0;
        #1;
        chk(tx_param, ro_exp(sup[c], acc + 32'(l1)));
        acc = acc + 32'(l1) + 32'(l2);
        nf += 2;
    endtask
    task automatic rx(input logic f, input logic [1:0] c, input logic o, input logic [31:0] p,
                      input logic [15:0] s, input logic [15:0] l, input logic [1:0] why, input logic [31:0] pl);
        @(posedge ref_clk);
        rx_frame <= 1'b1; rx_first <= f; rx_last <= lst; rx_cat <= c; rx_ro_present <= o;
        rx_param <= p; rx_seq <= s; rx_len <= l;
        @(posedge ref_clk);
        rx_frame <= 1'b0;
        #1;
        chk({30'h0, rx_accept, rx_rej}, {30'h0, why == 2'h0, why != 2'h0});
        chk({30'h0, rx_reason}, {30'h0, why});
        if (why == 2'h0) chk(rx_place, pl);
        chk({13'h0, rx_use_ro, rx_out_cat, rx_out_len}, {13'h0, o, c, l});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        apb(1'b0, CFG_OFS, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, CFG_OFS, {28'h0, sup});
        apb(1'b0, CFG_OFS, 32'h0);
        chk(r, {28'h0, sup});
        len = 16'h0;
        seg(1'b1, 1'b1, 2'h0, 1'b0);
        chk({31'h0, seg_err}, 32'h1);
        for (int c = 0; c < NCAT; c++) begin
            repeat (2) begin
                iro = (c == 0) ? OFS_ORIGIN : xs();
                len = 16'(xs() & 32'hff) + 16'h1;
                seg(1'b1, 1'b0, 2'(c), 1'b1);
                chk({31'h0, tx_ro_present}, {31'h0, sup[c]});
                chk(tx_param, ro_exp(sup[c], iro));
                acc = iro + 32'(len);
                repeat (3) begin
                    len = 16'(xs() & 32'hff) + 16'h1;
                    seg(1'b0, 1'b0, 2'(c), 1'b1);
                    chk(tx_param, ro_exp(sup[c], acc));
                    acc = acc + 32'(len);
                end
                len = 16'(xs() & 32'hff) + 16'h1;
                pair(2'(c), len, 16'(xs() & 32'h3f) + 16'h1);
            end
        end
        apb(1'b1, CFG_OFS, {23'h0, 1'b1, 4'h0, sup});
        repeat (3) begin
            iro = xs();
            len = 16'(xs() & 32'hff) + 16'h1;
            seg(1'b1, 1'b1, 2'h3, 1'b1);
            chk({30'h0, seg_err, tx_ro_present}, 32'h1);
            chk(tx_param, iro);
            seg(1'b0, 1'b0, 2'h3, 1'b1);
            chk(tx_param, iro + 32'(len));
        end
        // Request while frozen must never come out as a frame
        @(posedge ref_clk);
        ce <= 1'b0; frm_req <= 1'b1; frm_cat <= 2'h3;
        @(posedge ref_clk);
        ce <= 1'b1; frm_req <= 1'b0;
        #1;
        chk({31'h0, tx_valid}, 32'h0);
        apb(1'b0, TXCNT_OFS, 32'h0);
        chk({16'h0, r[15:0]}, 32'(nf));
        chk({frames, bad}, {16'(nf), 16'h0});
        apb(1'b1, CFG_OFS, {28'h0, sup});
        rx(1'b1, 2'h2, 1'b0, 32'h0, 16'hfffe, 16'd4, 2'h0, 32'd0);
        rx(1'b0, 2'h2, 1'b0, 32'h0, 16'hffff, 16'd10, 2'h0, 32'd4);
        rx(1'b0, 2'h2, 1'b0, 32'h0, 16'h0000, 16'd6, 2'h0, 32'd14);
        rx(1'b0, 2'h2, 1'b0, 32'h0, 16'h0005, 16'd4, 2'h3, 32'd0);
        rx(1'b0, 2'h2, 1'b1, 32'h9, 16'h0001, 16'd4, 2'h1, 32'd0);
        rx(1'b0, 2'h1, 1'b1, 32'd100, 16'h0001, 16'd8, 2'h0, 32'd100);
        rx(1'b0, 2'h1, 1'b1, 32'd108, 16'h0002, 16'd8, 2'h0, 32'd108);
        rx(1'b0, 2'h1, 1'b1, 32'd500, 16'h0003, 16'd8, 2'h2, 32'd0);
        apb(1'b0, REJCNT_OFS, 32'h0);
        chk({16'h0, r[15:0]}, 32'h3);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(r, 32'h0001_0003);
        lst = 1'b1;
        rx(1'b0, 2'h2, 1'b0, 32'h0, 16'h0003, 16'd2, 2'h0, 32'd20);
        lst = 1'b0;
        apb(1'b0, STAT_OFS, 32'h0);
        chk(r, 32'h0000_0004);
        apb(1'b1, STAT_OFS, 32'hffff_ffff);
        chk({31'h0, e}, 32'h0);
        // Mid-run reset must drop the login outcome and the counters
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        apb(1'b0, CFG_OFS, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, TXCNT_OFS, 32'h0);
        chk(r, 32'h0);
        summarize();
    end
endmodule // payload_segmentation_offset_tb
`default_nettype wire
